// file: core/sta_aux_cmd.v
/*
 auxiliary command handler of a scsi tape target: block-limits query,
 buffered-data recovery, unit release and sense request, with an axi4-lite
 register slave. assumes a scsi front end that hands over whole six-byte
 command blocks, drains data-in bytes with valid/ready and sends status;
 the write buffer presents unwritten bytes in recording order.
*/
// Overview of operation
// - opcode 05 returns block limits as data-in and never disconnects
// - limits data is six bytes: zero, 24-bit maximum, 16-bit minimum, msb first
// - maximum and minimum block length both report 512 bytes
// - opcode 14 sends blocks held in the write buffer, not from tape
// - recovered blocks leave in the order they would be recorded
// - recovery block count comes from command bytes two to four, msb first
// - over-asking recovery ends check condition, blank check, residue count; residue valid follows the fixed bit
// - with disconnect enabled the bus may be released during recovery
// - opcode 17 clears a reservation only for the initiator that made it
// - releasing an unreserved unit completes without error
// - third-party release clears only a matching third-party reservation
// - release and sense request never disconnect
// - opcode 03 returns held sense; sense clears only on another command
// - allocation of four or less sends exactly four standard sense bytes
// - allocation above four sends extended sense up to the defined maximum
// - link bit chains to the next command after good status
// - flag counts only with link; both set requests an interrupt
// - standard sense byte zero holds residue valid, error class and error code
`timescale 1ns/1ps
`include "sta_defs.vh"
module sta_aux_cmd #(
   parameter SENSE_MAX = `STA_SENSE_MAX
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        cmd_valid,
   output reg         cmd_ready,
   input  wire [47:0] cmd_cdb,
   input  wire [2:0]  cmd_initiator,
   output reg         din_valid,
   output reg  [7:0]  din_byte,
   output reg         din_last,
   input  wire        din_ready,
   input  wire [23:0] buf_blocks,
   input  wire        buf_valid,
   input  wire [7:0]  buf_byte,
   output reg         buf_ready,
   output reg         disc_allow,
   output reg         done_valid,
   output reg  [7:0]  done_status,
   output reg         done_link,
   output reg         done_irq,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   output reg  [1:0]  s_axi_bresp,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   input  wire [3:0]  s_axi_araddr,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp
);
// ------------------------------------------------------------
// state and storage
// ------------------------------------------------------------
localparam S_IDLE = 2'd0;
localparam S_EXEC = 2'd1;
localparam S_SEND = 2'd2;
localparam S_DONE = 2'd3;
localparam [23:0] BLK_LEN = `STA_BLK_LEN;
reg  [1:0]  state;
reg  [47:0] cdb;
reg  [2:0]  init_id;
reg  [32:0] rem;
reg  [3:0]  idx;
reg         from_buf;
reg         ext_fmt;
reg  [1:0]  err;
reg  [23:0] short_cnt;
reg         disc_en;
reg  [7:0]  resv;
reg         residue_valid;
reg  [2:0]  error_class_field;
reg  [3:0]  error_code_field;
reg  [3:0]  sense_key;
reg  [23:0] sense_info;
reg  [3:0]  aw_addr;
reg         aw_got;
reg  [31:0] w_data;
reg  [3:0]  w_strb;
reg         w_got;
wire [7:0]  op = cdb[47:40];
wire [7:0]  alloc = cdb[15:8];
wire [23:0] req_blocks = cdb[31:8];
wire [23:0] xfer_blocks = (req_blocks > buf_blocks) ? buf_blocks : req_blocks;
wire        wr_go = aw_got && w_got && !s_axi_bvalid;
// ------------------------------------------------------------
// functions
// ------------------------------------------------------------
// reserved bits of each accepted command block must be zero
function cdb_ok;
   input [47:0] c;
   begin
      case (c[47:40])
         `STA_OP_LIMITS:  cdb_ok = (c[39:8] == 32'h0) && (c[7:2] == 6'h0);
         `STA_OP_RECOVER: cdb_ok = (c[39:33] == 7'h0) && (c[7:2] == 6'h0);
         `STA_OP_RELEASE: cdb_ok = (c[39:37] == 3'h0) && !c[32] && (c[31:8] == 24'h0) && (c[7:2] == 6'h0);
         `STA_OP_SENSE:   cdb_ok = (c[39:16] == 24'h0) && (c[7:2] == 6'h0);
         default:         cdb_ok = 1'b0;
      endcase
   end
endfunction
function [7:0] gen_byte;
   input       is_sense;
   input       ext;
   input [3:0] i;
   input [7:0] b0;
   input [3:0] key;
   input [23:0] info;
   reg   [55:0] lim;
   reg   [63:0] ex;
   reg   [31:0] st;
   begin
      lim = {8'h00, BLK_LEN, BLK_LEN[15:0], 8'h00};
      ex  = {b0[7], `STA_EXT_HDR, 8'h00, 4'h0, key, 8'h00, info, 8'h00};
      st  = {b0, 4'h0, info[19:0]};
      if (!is_sense)
         gen_byte = lim[8*(6-i)+:8];
      else if (ext)
         gen_byte = ex[8*(7-i)+:8];
      else
         gen_byte = st[8*(3-i)+:8];
   end
endfunction
// ------------------------------------------------------------
// command sequencer
// ------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
   if (!rst_n) begin
      state             <= S_IDLE;
      cdb               <= 48'h0;
      init_id           <= 3'h0;
      rem               <= 33'h0;
      idx               <= 4'h0;
      from_buf          <= 1'b0;
      ext_fmt           <= 1'b0;
      err               <= 2'b00;
      short_cnt         <= 24'h0;
      cmd_ready         <= 1'b0;
      din_valid         <= 1'b0;
      din_byte          <= 8'h00;
      din_last          <= 1'b0;
      buf_ready         <= 1'b0;
      disc_allow        <= 1'b0;
      done_valid        <= 1'b0;
      done_status       <= 8'h00;
      done_link         <= 1'b0;
      done_irq          <= 1'b0;
      resv              <= `STA_RESV_RST;
      residue_valid     <= 1'b0;
      error_class_field <= 3'h0;
      error_code_field  <= 4'h0;
      sense_key         <= 4'h0;
      sense_info        <= 24'h0;
   end else begin
      done_valid <= 1'b0;
      // software loads sense and reservations for the wider controller
      if (wr_go && aw_addr == `STA_OFF_RESV && w_strb[0])
         resv <= w_data[7:0];
      if (wr_go && aw_addr == `STA_OFF_SENSE && w_strb[0])
         {residue_valid, error_class_field, error_code_field} <= w_data[7:0];
      if (wr_go && aw_addr == `STA_OFF_SENSE && w_strb[1])
         sense_key <= w_data[11:8];
      if (wr_go && aw_addr == `STA_OFF_INFO)
         sense_info <= w_data[23:0];
      case (state)
         S_IDLE: begin
            cmd_ready <= 1'b1;
            if (cmd_valid && cmd_ready) begin
               cmd_ready <= 1'b0;
               cdb       <= cmd_cdb;
               init_id   <= cmd_initiator;
               state     <= S_EXEC;
            end
         end
         S_EXEC: begin
            idx      <= 4'h0;
            from_buf <= 1'b0;
            ext_fmt  <= 1'b0;
            err      <= 2'b00;
            rem      <= 33'h0;
            state    <= S_SEND;
            // held sense survives a sense request only
            if (op != `STA_OP_SENSE) begin
               residue_valid     <= 1'b0;
               error_class_field <= 3'h0;
               error_code_field  <= 4'h0;
               sense_key         <= 4'h0;
               sense_info        <= 24'h0;
            end
            if (!cdb_ok(cdb))
               err <= 2'b10;
            else
               case (op)
                  `STA_OP_LIMITS: rem <= `STA_LIMITS_LEN;
                  `STA_OP_RECOVER: begin
                     from_buf   <= 1'b1;
                     rem        <= {xfer_blocks, 9'h000};
                     short_cnt  <= req_blocks - xfer_blocks;
                     disc_allow <= disc_en;
                     if (req_blocks > buf_blocks)
                        err <= 2'b01;
                  end
                  `STA_OP_RELEASE: begin
                     // a mismatching or absent reservation still ends good
                     if (resv[`STA_RESV_ON] && resv[3:1] == init_id &&
                         resv[`STA_RESV_TP] == cdb[36] &&
                         (!cdb[36] || resv[7:5] == cdb[35:33]))
                        resv[`STA_RESV_ON] <= 1'b0;
                  end
                  default: begin
                     ext_fmt <= (alloc > 8'd4);
                     if (alloc <= 8'd4)
                        rem <= `STA_STD_LEN;
                     else if (alloc > SENSE_MAX[7:0])
                        rem <= {25'h0, SENSE_MAX[7:0]};
                     else
                        rem <= {25'h0, alloc};
                  end
               endcase
         end
         S_SEND: begin
            buf_ready <= 1'b0;
            if (din_valid && din_ready) begin
               din_valid <= 1'b0;
               din_last  <= 1'b0;
            end else if (rem == 33'h0 && !din_valid) begin
               state <= S_DONE;
            end else if (!din_valid && from_buf) begin
               // one byte in flight keeps the buffer order intact
               buf_ready <= !buf_ready && !(buf_valid && buf_ready);
               if (buf_valid && buf_ready) begin
                  din_valid <= 1'b1;
                  din_byte  <= buf_byte;
                  din_last  <= (rem == 33'h1);
                  rem       <= rem - 33'h1;
               end
            end else if (!din_valid) begin
               din_valid <= 1'b1;
               din_byte  <= gen_byte(op == `STA_OP_SENSE, ext_fmt, idx,
                                     {residue_valid, error_class_field, error_code_field},
                                     sense_key, sense_info);
               din_last  <= (rem == 33'h1);
               idx       <= idx + 4'h1;
               rem       <= rem - 33'h1;
            end
         end
         default: begin
            disc_allow  <= 1'b0;
            done_valid  <= 1'b1;
            done_status <= (err == 2'b00) ? `STA_ST_GOOD : `STA_ST_CHECK;
            done_link   <= (err == 2'b00) && cdb[0];
            done_irq    <= (err == 2'b00) && cdb[0] && cdb[1];
            if (err == 2'b01) begin
               residue_valid <= cdb[32];
               {error_class_field, error_code_field} <= `STA_STD_BLANK;
               sense_key     <= `STA_KEY_BLANK;
               sense_info    <= short_cnt;
            end else if (err == 2'b10) begin
               {error_class_field, error_code_field} <= `STA_STD_ILLEGAL;
               sense_key     <= `STA_KEY_ILLEGAL;
            end
            state <= S_IDLE;
         end
      endcase
   end
end
// ------------------------------------------------------------
// axi4-lite slave
// ------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
   if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `STA_RSP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `STA_RSP_OKAY;
      aw_addr       <= 4'h0;
      aw_got        <= 1'b0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      w_got         <= 1'b0;
      disc_en       <= `STA_CTRL_RST;
   end else begin
      s_axi_awready <= !aw_got && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_got && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
         aw_addr <= s_axi_awaddr;
         aw_got  <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
         w_got  <= 1'b1;
      end
      if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_addr[1:0] == 2'b00) ? `STA_RSP_OKAY : `STA_RSP_SLVERR;
         if (aw_addr == `STA_OFF_CTRL && w_strb[0])
            disc_en <= w_data[`STA_CTRL_DISC];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
         aw_got       <= 1'b0;
         w_got        <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `STA_RSP_OKAY;
         case (s_axi_araddr)
            `STA_OFF_CTRL:  s_axi_rdata <= {29'h0, state, disc_en};
            `STA_OFF_RESV:  s_axi_rdata <= {24'h0, resv};
            `STA_OFF_SENSE: s_axi_rdata <= {20'h0, sense_key, residue_valid,
                                            error_class_field, error_code_field};
            `STA_OFF_INFO:  s_axi_rdata <= {8'h0, sense_info};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= `STA_RSP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
end
endmodule // sta_aux_cmd

// file: core/sta_defs.vh
/*
 holds the constants of the auxiliary tape command handler: bus offsets,
 field positions, reset values, opcodes, sense codes and transfer sizes.
 assumes inclusion by bare name from the design file only.
*/
`ifndef STA_DEFS_VH
`define STA_DEFS_VH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define STA_OFF_CTRL    4'h0
`define STA_OFF_RESV    4'h4
`define STA_OFF_SENSE   4'h8
`define STA_OFF_INFO    4'hc
// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define STA_CTRL_DISC   0
`define STA_RESV_ON     0
`define STA_RESV_TP     4
`define STA_CTRL_RST    1'b0
`define STA_RESV_RST    8'h00
`define STA_RSP_OKAY    2'b00
`define STA_RSP_SLVERR  2'b10
// ------------------------------------------------------------
// opcodes, status and sense values
// ------------------------------------------------------------
`define STA_OP_SENSE    8'h03
`define STA_OP_LIMITS   8'h05
`define STA_OP_RECOVER  8'h14
`define STA_OP_RELEASE  8'h17
`define STA_ST_GOOD     8'h00
`define STA_ST_CHECK    8'h02
`define STA_KEY_BLANK   4'h8
`define STA_KEY_ILLEGAL 4'h5
`define STA_STD_BLANK   7'h34
`define STA_STD_ILLEGAL 7'h20
`define STA_EXT_HDR     7'h70
// ------------------------------------------------------------
// transfer sizes
// ------------------------------------------------------------
`define STA_BLK_LEN     24'h000200
`define STA_LIMITS_LEN  33'h000000006
`define STA_STD_LEN     33'h000000004
`define STA_SENSE_MAX   8
`endif

// file: verification/sta_aux_monitor.sv
/*
 checker of the auxiliary command handler, bound to its top ports.
 assumes one clk domain with rst_n as asynchronous active-low reset.
*/
`timescale 1ns/1ps
module sta_aux_monitor #(
   parameter SENSE_MAX = 8
) (
   input wire        clk,
   input wire        rst_n,
   input wire        cmd_valid,
   input wire        cmd_ready,
   input wire [47:0] cmd_cdb,
   input wire        din_valid,
   input wire [7:0]  din_byte,
   input wire        din_last,
   input wire        din_ready,
   input wire        disc_allow,
   input wire        done_valid,
   input wire [7:0]  done_status,
   input wire        done_link,
   input wire        done_irq
);
   wire       take = cmd_valid && cmd_ready;
   wire [7:0] op   = cmd_cdb[47:40];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_limits_first;
      take && cmd_cdb[47:8] == 40'h0500000000 |-> ##[1:4] (din_valid && din_byte == 8'h00);
   endproperty
   a_limits_first: assert property (p_limits_first) else $error("limits data does not start with zero");
   property p_no_disc;
      take && op != 8'h14 |=> !disc_allow [*8];
   endproperty
   a_no_disc: assert property (p_no_disc) else $error("disconnect allowed outside recovery");
   property p_din_hold;
      din_valid && !din_ready |=> din_valid && $stable(din_byte) && $stable(din_last);
   endproperty
   a_din_hold: assert property (p_din_hold) else $error("data-in byte dropped before acceptance");
   property p_done_pulse;
      done_valid |=> !done_valid;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("status pulse longer than one cycle");
   property p_release_good;
      take && cmd_cdb[47:8] == 40'h1700000000 |-> ##[3:5] (done_valid && done_status == 8'h00);
   endproperty
   a_release_good: assert property (p_release_good) else $error("plain release not good in time");
   property p_irq;
      done_valid && done_irq |-> done_link && done_status == 8'h00;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without link or good status");
   property p_link;
      done_valid && done_status == 8'h02 |-> !done_link && !done_irq;
   endproperty
   a_link: assert property (p_link) else $error("link reported on check condition");
   property p_reserved;
      take && op == 8'h05 && cmd_cdb[39:2] != 38'h0 |-> ##[2:6] (done_valid && done_status == 8'h02);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not refused");
   property p_last_done;
      din_valid && din_ready && din_last |-> ##[1:3] done_valid;
   endproperty
   a_last_done: assert property (p_last_done) else $error("no status after final byte");
   c_recover: cover property (take && op == 8'h14);
   c_check: cover property (done_valid && done_status == 8'h02);
   c_irq: cover property (done_valid && done_irq);
endmodule // sta_aux_monitor
bind sta_aux_cmd sta_aux_monitor #(.SENSE_MAX(SENSE_MAX)) sta_aux_monitor_i (
   .clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_cdb, .din_valid, .din_byte, .din_last,
   .din_ready, .disc_allow, .done_valid, .done_status, .done_link, .done_irq
);

// file: verification/sta_init_model.sv
/*
 initiator-side partner: accepts data-in bytes into rx_q and feeds the
 write-buffer stream. assumes buffer bytes count up from zero after reset.
*/
`timescale 1ns/1ps
module sta_init_model (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       slow,
   input  wire       din_valid,
   input  wire [7:0] din_byte,
   input  wire       din_last,
   output reg        din_ready,
   output reg        buf_valid,
   output reg  [7:0] buf_byte,
   input  wire       buf_ready
);
   logic [7:0] rx_q[$];
   logic       rx_last[$];
   logic [7:0] seq;
   logic [1:0] tick;
   wire  [7:0] nseq  = seq + {7'h0, buf_valid && buf_ready};
   wire        offer = !slow || tick[0];
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         din_ready <= 1'b0;
         buf_valid <= 1'b0;
         buf_byte  <= 8'hff;
         seq       <= 8'h00;
         tick      <= 2'h0;
      end else begin
         tick      <= tick + 2'h1;
         seq       <= nseq;
         // slow mode stalls both streams so the hold rules get exercised
         din_ready <= !slow || tick == 2'h0;
         if (din_valid && din_ready) begin
            rx_q.push_back(din_byte);
            rx_last.push_back(din_last);
         end
         // an idle buffer shows a moving non-data value, never the next byte
         if (!buf_valid || buf_ready) begin
            buf_valid <= offer;
            buf_byte  <= offer ? nseq : ~nseq ^ {6'h0, tick};
         end
      end
   end
endmodule // sta_init_model

// file: verification/tb_sta_aux_cmd.sv
/*
 self-checking bench of the auxiliary command handler.
 assumes the partner in sta_init_model.sv and the bound checker.
*/
`timescale 1ns/1ps
module tb_sta_aux_cmd;
   logic        clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, slow = 1'b0;
   logic [47:0] cmd_cdb = 48'h0;
   logic [2:0]  cmd_initiator = 3'h0;
   logic [23:0] buf_blocks = 24'h0;
   logic        cmd_ready, din_valid, din_last, din_ready, buf_valid, buf_ready, disc_allow;
   logic        done_valid, done_link, done_irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic [7:0]  din_byte, buf_byte, done_status;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_arready, s_axi_rvalid;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic [7:0]  st;
   logic        lk, iq, dsc;
   int          error_cnt = 0, cmp_count = 0, i;
   localparam logic [3:0] vol_ovf_key = 4'h1; // arbitrary stand-in code for the overflow key
   sta_aux_cmd sta_aux_cmd_i (.*);
   sta_init_model sta_init_model_i (.*);
   initial begin
      forever #5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task axi_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task axi_rd(input logic [3:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task run_cmd(input logic [47:0] c, input logic [2:0] ini);
      @(posedge clk);
      sta_init_model_i.rx_q.delete();
      sta_init_model_i.rx_last.delete();
      dsc = 1'b0;
      cmd_cdb <= c;
      cmd_initiator <= ini;
      cmd_valid <= 1'b1;
      do @(posedge clk); while (!cmd_ready);
      cmd_valid <= 1'b0;
      for (i = 0; i < 20000 && !done_valid; i++) begin
         @(posedge clk);
         dsc = dsc | disc_allow;
      end
      if (!done_valid) begin
         check(32'(done_valid), 32'h1);
         stop_test;
      end
      st = done_status;
      lk = done_link;
      iq = done_irq;
   endtask
   task chk_q(input logic [7:0] e[$]);
      check(32'(sta_init_model_i.rx_q.size()), 32'(e.size()));
      foreach (e[k])
         check(32'({sta_init_model_i.rx_q[k], sta_init_model_i.rx_last[k]}), 32'({e[k], k == e.size() - 1}));
   endtask
   task chk_buf;
      check(32'(sta_init_model_i.rx_q.size()), 32'd512);
      for (i = 0; i < 512; i++)
         check(32'({sta_init_model_i.rx_q[i], sta_init_model_i.rx_last[i]}), 32'({i[7:0], i == 511}));
   endtask
   task rel(input logic [31:0] rv, input logic [7:0] b1, input logic [2:0] ini, input logic [31:0] ex);
      axi_wr(4'h4, rv);
      check(32'(rr), 32'h0);
      run_cmd({8'h17, b1, 32'h0}, ini);
      check(32'(st), 32'h0);
      check(32'(dsc), 32'h0);
      axi_rd(4'h4);
      check(rd, ex);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_recover;
      buf_blocks <= 24'h1;
      axi_wr(4'h8, {20'h0, vol_ovf_key, 8'h00}); // overflow key held before recovery
      axi_rd(4'h8);
      check(rd, {20'h0, vol_ovf_key, 8'h00});
      run_cmd({8'h14, 8'h01, 24'h1, 8'h01}, 3'h1);
      check(32'({st, lk, dsc}), 32'h002);
      chk_buf;
      slow <= 1'b1;
      axi_wr(4'h0, 32'h1);
      run_cmd({8'h14, 8'h01, 24'h2, 8'h00}, 3'h1); // fixed bit set so the residue shows
      check(32'(st), 32'h2);
      check(32'(dsc), 32'h1);
      chk_buf;
      axi_rd(4'h8);
      check(rd, 32'h8b4);
      axi_rd(4'hc);
      check(rd, 32'h1);
      slow <= 1'b0;
      axi_wr(4'h0, 32'h0);
      $display("recover test done");
   endtask
   task t_sense;
      run_cmd({8'h03, 24'h0, 8'h04, 8'h00}, 3'h1);
      chk_q('{8'hb4, 8'h00, 8'h00, 8'h01});
      run_cmd({8'h03, 24'h0, 8'h05, 8'h00}, 3'h2);
      chk_q('{8'hf0, 8'h00, 8'h08, 8'h00, 8'h00});
      run_cmd({8'h03, 24'h0, 8'h10, 8'h00}, 3'h1);
      chk_q('{8'hf0, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00});
      check(32'(dsc), 32'h0);
      $display("sense test done");
   endtask
   task t_limits;
      for (int n = 1; n < 4; n++) begin
         slow <= n[0];
         run_cmd({8'h05, 32'h0, n[7:0]}, 3'h2);
         chk_q('{8'h00, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00});
         check(32'({st, lk, iq}), 32'({8'h00, n[0], n == 3}));
      end
      axi_rd(4'h8);
      check(rd, 32'h0);
      $display("limits test done");
   endtask
   task t_reserved;
      run_cmd({8'h05, 8'h01, 32'h0}, 3'h2);
      check(32'({st, 8'(sta_init_model_i.rx_q.size())}), 32'h0200);
      axi_rd(4'h8);
      check(rd, 32'h520);
      axi_rd(4'h2);
      check(32'(rr), 32'h2);
      axi_wr(4'h6, 32'hff);
      check(32'(rr), 32'h2);
      $display("reserved test done");
   endtask
   task t_release;
      axi_rd(4'h4);
      check(rd, 32'h0);
      rel(32'h07, 8'h00, 3'h2, 32'h07);
      rel(32'h07, 8'h00, 3'h3, 32'h06);
      rel(32'h06, 8'h00, 3'h3, 32'h06);
      rel(32'hb7, 8'h00, 3'h3, 32'hb7);
      rel(32'hb7, 8'h18, 3'h3, 32'hb7);
      rel(32'hb7, 8'h1a, 3'h2, 32'hb7);
      rel(32'hb7, 8'h1a, 3'h3, 32'hb6);
      $display("release test done");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_release;
      t_recover;
      t_sense;
      t_limits;
      t_reserved;
      stop_test;
   end
   initial begin
      #300000;
      error_cnt++;
      stop_test;
   end
endmodule // tb_sta_aux_cmd
